/* File: spl_pkg.sv */
// constants shared by the serial-in parallel-out latch and its buffer
package spl_pkg;
	// stage count of the shift chain and of the storage register
	localparam int          SPL_WIDTH    = 8;
	// depth of the buffer between the shift chain and the storage register
	localparam int          SPL_DEPTH    = 2;
	// positions of the pin inputs inside the synchroniser vectors
	localparam int          SPL_IDX_SER  = 0;
	localparam int          SPL_IDX_SCLK = 1;
	localparam int          SPL_IDX_RCLK = 2;
	localparam int          SPL_IDX_CLR  = 3;
	localparam int          SPL_IDX_OE   = 4;
	localparam int          SPL_PINS     = 5;
	// reset value of the synchronisers: clocks low, clear active, outputs off
	localparam logic [4:0]  SPL_SYNC_RST = 5'h10;
	// system clock period in nanoseconds, for reference in the latency figures
	localparam int          SPL_CLK_NS   = 25;
endpackage

/* File: spl_buf2.sv */
// small first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
module spl_buf2
	import spl_pkg::*;
#(
	parameter int WIDTH = SPL_WIDTH,
	parameter int DEPTH = SPL_DEPTH
) (
	// clock and reset
	input  wire logic             clock_i,
	input  wire logic             reset_n_i,
	// filling side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// draining side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	// pointers wrap freely, so only powers of two are served
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_check
		$error("spl_buf2: DEPTH must be a power of two of at least 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wr;
		logic [PW-1:0]               rd;
		logic [CW-1:0]               cnt;
	} spl_buf_s;

	spl_buf_s s;
	spl_buf_s next_s;
	logic     push;
	logic     pop;

	// honest full and empty straight from the occupancy count
	assign in_ready_o  = (s.cnt != CW'(DEPTH));
	assign out_valid_o = (s.cnt != '0);
	assign out_data_o  = s.mem[s.rd];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	// next state of pointers, count and storage
	always_comb begin
		next_s = s;
		if (push) begin
			next_s.mem[s.wr] = in_data_i;
			next_s.wr        = s.wr + PW'(1);
		end
		if (pop) begin
			next_s.rd = s.rd + PW'(1);
		end
		if (push && !pop) begin
			next_s.cnt = s.cnt + CW'(1);
		end else if (pop && !push) begin
			next_s.cnt = s.cnt - CW'(1);
		end
	end

	// state register, synchronous reset empties the buffer
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule

/* File: spl_latch.sv */
// serial-in parallel-out shift chain with storage register and gated outputs
// How it works
// - eight-stage shift chain feeds eight-bit storage register
// - storage bits drive parallel outputs when enabled
// - enable high floats outputs; cascade never floats
// - each register acts on its own rising clock
// - clear low zeroes shift chain, overriding shifts
// - shift edge: first takes input, others shift
// - storage edge captures all shift stages together
// - tied clocks: storage lags shift by one
// - serial cascade output feeds next device
`timescale 1ns/1ps
module spl_latch
	import spl_pkg::*;
#(
	parameter int WIDTH = SPL_WIDTH,
	parameter int DEPTH = SPL_DEPTH
) (
	// clock and reset
	input  wire logic             clock_i,
	input  wire logic             reset_n_i,
	// pins from the driving controller, asynchronous to clock_i
	input  wire logic             serial_in_i,
	input  wire logic             shift_clock_i,
	input  wire logic             store_clock_i,
	input  wire logic             shift_clear_n_i,
	input  wire logic             output_enable_n_i,
	// parallel three-state outputs, split into value and enable
	output logic      [WIDTH-1:0] parallel_out_o,
	output logic      [WIDTH-1:0] parallel_oe_o,
	// cascade output, always driven
	output logic                  cascade_out_o
);
	if (WIDTH < 2) begin : g_check
		$error("spl_latch: WIDTH must be at least 2");
	end

	typedef struct packed {
		logic [SPL_PINS-1:0] sync1;   // first synchroniser stage
		logic [SPL_PINS-1:0] sync2;   // second synchroniser stage
		logic                sclk_d;  // delayed shift clock for edge detect
		logic                rclk_d;  // delayed store clock for edge detect
		logic [WIDTH-1:0]    shift;   // shift chain, bit 0 is the first stage
		logic [WIDTH-1:0]    storage; // storage register
		logic                drive;   // parallel drivers enabled
	} spl_latch_s;

	spl_latch_s       s;
	spl_latch_s       next_s;
	logic             ser_s;
	logic             shift_rise;
	logic             store_rise;
	logic             clear;
	logic             buf_in_ready;
	logic             buf_out_valid;
	logic [WIDTH-1:0] buf_out_data;

	// decoded pin events, only ever from the second synchroniser stage
	assign ser_s      = s.sync2[SPL_IDX_SER];
	assign shift_rise = s.sync2[SPL_IDX_SCLK] & ~s.sclk_d;
	assign store_rise = s.sync2[SPL_IDX_RCLK] & ~s.rclk_d;
	assign clear      = ~s.sync2[SPL_IDX_CLR];

	// snapshot of the chain travels through the buffer to the storage register;
	// the snapshot is taken before this cycle's shift lands, so tied clocks lag
	spl_buf2 #(
		.WIDTH (WIDTH),
		.DEPTH (DEPTH)
	) u_buf (
		.clock_i     (clock_i),
		.reset_n_i   (reset_n_i),
		.in_valid_i  (store_rise),
		.in_ready_o  (buf_in_ready),
		.in_data_i   (s.shift),
		.out_valid_o (buf_out_valid),
		.out_ready_i (1'b1),
		.out_data_o  (buf_out_data)
	);

	// next state of synchronisers, shift chain, storage and output drive
	always_comb begin
		next_s        = s;
		next_s.sync1  = {output_enable_n_i, shift_clear_n_i, store_clock_i,
			shift_clock_i, serial_in_i};
		next_s.sync2  = s.sync1;
		next_s.sclk_d = s.sync2[SPL_IDX_SCLK];
		next_s.rclk_d = s.sync2[SPL_IDX_RCLK];
		if (clear) begin
			next_s.shift = '0; // clear wins over any shift edge
		end else if (shift_rise) begin
			next_s.shift = {s.shift[WIDTH-2:0], ser_s};
		end
		// clear has no path here, storage moves only on a buffered snapshot
		if (buf_out_valid) begin
			next_s.storage = buf_out_data;
		end
		next_s.drive = ~s.sync2[SPL_IDX_OE];
	end

	// state register with synchronous reset
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			s         <= '0;
			s.sync1   <= SPL_SYNC_RST;
			s.sync2   <= SPL_SYNC_RST;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from flip-flops; the enable never touches the cascade
	assign parallel_out_o = s.storage;
	assign parallel_oe_o  = {WIDTH{s.drive}};
	assign cascade_out_o  = s.shift[WIDTH-1];

	// checks run on the system clock and sleep while reset is held; pin causes are
	// read after the synchronisers, so every latency counts from the second stage
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!reset_n_i);

	sequence store_taken;
		store_rise ##0 buf_in_ready;
	endsequence

	sequence chain_steps;
		shift_rise && !clear;
	endsequence

	a_clear_zeroes_chain: assert property (
		clear |=> (s.shift == '0))
		else $error("shift chain not zero after clear");

	a_shift_step_in: assert property (
		chain_steps |=> (s.shift[0] == $past(ser_s)) &&
			(s.shift[WIDTH-1:1] == $past(s.shift[WIDTH-2:0])))
		else $error("shift chain did not step by one stage");

	a_chain_holds_idle: assert property (
		(!shift_rise && !clear) |=> $stable(s.shift))
		else $error("shift chain moved without a shift edge");

	a_store_lags_chain: assert property (
		store_taken |-> ##2 (parallel_out_o == $past(s.shift, 2)))
		else $error("storage did not capture the chain two cycles on");

	a_storage_kept_clear: assert property (
		(clear && !buf_out_valid) |=> $stable(parallel_out_o))
		else $error("storage changed on clear alone");

	a_oe_follows_pin: assert property (
		(s.sync2[SPL_IDX_OE] ##1 s.sync2[SPL_IDX_OE]) |=> (parallel_oe_o == '0))
		else $error("parallel outputs driven while enable high");

	a_oe_drives_low: assert property (
		!s.sync2[SPL_IDX_OE] |=> (parallel_oe_o == '1))
		else $error("parallel outputs floating while enable low");

	a_cascade_low_clear: assert property (
		clear |=> !cascade_out_o)
		else $error("cascade output not low after clear");

	a_tied_clocks_lag: assert property (
		(store_rise && shift_rise && !clear) |-> ##2
			(parallel_out_o == $past(s.shift, 2)) && (s.shift != $past(s.shift, 2) ||
			$past(s.shift[WIDTH-2:0], 2) == $past(s.shift[WIDTH-1:1], 2)))
		else $error("storage did not lag the chain with tied clocks");

	a_store_never_lost: assert property (
		store_rise |-> buf_in_ready)
		else $error("store edge met a full buffer");

	// a snapshot waits one cycle in the buffer, then lands in storage
	sequence snapshot_lands;
		##1 buf_out_valid ##1 (parallel_out_o == $past(s.shift, 2));
	endsequence

	sequence tied_edge;
		store_rise && shift_rise && !clear;
	endsequence

	a_snapshot_path: assert property (
		store_taken |-> snapshot_lands)
		else $error("snapshot did not pass the buffer into storage");

	// with both edges in one cycle storage must see the chain from before the shift
	a_tied_pre_edge: assert property (
		tied_edge |-> snapshot_lands)
		else $error("tied clocks stored the shifted chain");

	// the store side is always ready, so a snapshot never lingers
	a_buffer_drains: assert property (
		buf_out_valid |=> !buf_out_valid)
		else $error("buffer held a snapshot for more than one cycle");

	a_storage_from_buf: assert property (
		buf_out_valid |=> (parallel_out_o == $past(buf_out_data)))
		else $error("storage did not take the buffered snapshot");

	// storage moves on its own clock only, never on shifts or clears
	a_storage_own_clock: assert property (
		!buf_out_valid |=> $stable(parallel_out_o))
		else $error("storage moved without a store edge");

	// a long pin level must act once, not on every cycle it stays high
	a_shift_rise_once: assert property (
		shift_rise |=> !shift_rise)
		else $error("shift edge seen on two cycles in a row");

	a_store_rise_once: assert property (
		store_rise |=> !store_rise)
		else $error("store edge seen on two cycles in a row");

	// the cascade pin shows the stage that was second to last
	a_cascade_steps: assert property (
		chain_steps |=> (cascade_out_o == $past(s.shift[WIDTH-2])))
		else $error("cascade output did not follow the last stage");

	// an edge under clear is dropped, not held back for later
	a_clear_drops_edge: assert property (
		(clear && shift_rise) |=> (s.shift == '0) && !cascade_out_o)
		else $error("shift edge acted while clear was low");

	a_oe_release: assert property (
		s.sync2[SPL_IDX_OE] |=> (parallel_oe_o == '0))
		else $error("parallel drivers stayed on after enable went high");
endmodule

/* File: spl_ctrl.sv */
// controller model that drives the latch pins
`timescale 1ns/1ps
module spl_ctrl (
	// clock
	input  wire logic clock_i,
	// pins
	output logic      serial_in_o,
	output logic      shift_clock_o,
	output logic      store_clock_o,
	output logic      shift_clear_n_o,
	output logic      output_enable_n_o
);
	// quiet pins: clocks low, clear off, outputs off
	initial begin
		{serial_in_o, shift_clock_o, store_clock_o} = 3'h0;
		{shift_clear_n_o, output_enable_n_o} = 2'h3;
	end
	// levels held four cycles so the two-flop synchronisers see each one
	task automatic pulse(input logic sh, input logic st, input logic d);
		@(negedge clock_i) serial_in_o = d;
		repeat (3) @(negedge clock_i);
		{shift_clock_o, store_clock_o} = {sh, st}; // both at once ties the clocks
		repeat (4) @(negedge clock_i);
		{shift_clock_o, store_clock_o} = 2'h0;
		repeat (4) @(negedge clock_i);
	endtask
	// clear and enable levels, then settle
	task automatic level(input logic clr_n, input logic oe_n);
		@(negedge clock_i) {shift_clear_n_o, output_enable_n_o} = {clr_n, oe_n};
		repeat (5) @(negedge clock_i);
	endtask
endmodule

/* File: test_spl_latch.sv */
// self-checking bench for the serial-in parallel-out latch
`timescale 1ns/1ps
`define CMP(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
	$display("MISMATCH %0t got %h want %h", $time, a, e); end end
module test_spl_latch;
	import spl_pkg::*;
	typedef struct packed {logic [7:0] o; logic [7:0] e; logic c;} spl_exp_s;
	logic       clock_i = 1'b0;
	logic       reset_n_i = 1'b0;
	logic       serial_in, sclk, rclk, clr_n, oe_n, casc;
	logic [7:0] pout, poe;
	logic [7:0] chain = 8'h00, stor = 8'h00, oe_exp = 8'h00;
	logic       clr = 1'b1;
	logic [31:0] seed = 32'hada6;
	int         miscompares = 0, checks = 0;
	spl_exp_s   q[$];
	spl_exp_s   x;
	event       note_ev;
	// 40 MHz clock
	always #(SPL_CLK_NS / 2.0) clock_i = ~clock_i;
	spl_latch u_spl_latch (.clock_i(clock_i), .reset_n_i(reset_n_i), .serial_in_i(serial_in),
		.shift_clock_i(sclk), .store_clock_i(rclk), .shift_clear_n_i(clr_n),
		.output_enable_n_i(oe_n), .parallel_out_o(pout), .parallel_oe_o(poe),
		.cascade_out_o(casc));
	spl_ctrl u_spl_ctrl (.clock_i(clock_i), .serial_in_o(serial_in), .shift_clock_o(sclk),
		.store_clock_o(rclk), .shift_clear_n_o(clr_n), .output_enable_n_o(oe_n));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// note what the outputs should show once the pins have settled
	task automatic note();
		q.push_back('{stor, oe_exp, chain[7]});
		->note_ev;
	endtask
	// store before shift, so tied clocks capture the pre-edge chain
	task automatic op(input logic sh, input logic st, input logic d);
		if (st) stor = chain;
		if (sh && clr) chain = {chain[6:0], d}; // clear overrides shifts
		u_spl_ctrl.pulse(sh, st, d);
		note();
	endtask
	// clear empties only the chain; storage keeps its word
	task automatic lvl(input logic c, input logic e);
		clr = c;
		if (!c) chain = 8'h00;
		oe_exp = e ? 8'h00 : 8'hff;
		u_spl_ctrl.level(c, e);
		note();
	endtask
	task automatic close_out();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// watcher takes the oldest note whenever a result is due
	initial forever begin
		@(note_ev);
		x = q.pop_front();
		`CMP(pout, x.o)
		`CMP(poe, x.e)
		`CMP(casc, x.c)
	end
	// hang guard, far beyond the roughly five hundred cycles the tests take
	initial begin
		#(SPL_CLK_NS * 20000);
		miscompares++;
		close_out();
	end
	// main sequence
	initial begin
		repeat (5) @(negedge clock_i);
		reset_n_i = 1'b1;
		note();
		lvl(1'b1, 1'b0);
		// random bits, some with the clocks tied together
		for (int i = 0; i < 24; i++) begin
			seed = lfsr(seed);
			op(1'b1, seed[3], seed[0]);
		end
		op(1'b0, 1'b1, 1'b0);
		for (int i = 0; i < 8; i++) op(1'b1, 1'b0, 1'b1); // ones reach the cascade
		lvl(1'b0, 1'b0);
		op(1'b1, 1'b0, 1'b1); // shift edge under clear is ignored
		lvl(1'b1, 1'b1); // cascade keeps driving while outputs float
		op(1'b1, 1'b0, 1'b1);
		lvl(1'b1, 1'b0);
		op(1'b0, 1'b1, 1'b0);
		// reset in mid-run: storage and drivers drop at once, pins are taken up again
		@(negedge clock_i) reset_n_i = 1'b0;
		repeat (3) @(negedge clock_i);
		reset_n_i = 1'b1;
		{chain, stor, oe_exp} = 24'h000000;
		note();
		lvl(1'b1, 1'b0);
		op(1'b1, 1'b1, 1'b1); // storage restarts from zero
		op(1'b0, 1'b1, 1'b0);
		close_out();
	end
endmodule
